// ---- rtl/fsp_cfg.sv ----
// Summary of operation
// - options register loaded from flash each reset
// - backdoor enable low blocks key unlock
// - matching ordered eight-byte key unsecures device
// - key writes only from secure firmware
// - bit six disables vector redirection
// - security code one-zero unsecured, else secure
// - secure state blocks unsecured memory access
// - key match or blank pass unsecures
// - steer low: key writes are command steps
// - steer high: key writes captured as key
// - protection register loaded from flash each reset
// - protection readable, user writes ignored
// - debug commands may write protection register
// - select field sets end of unprotected region
// - no erase or program in protected block
// - protect disable high leaves nothing protected
// - steer falling after eight writes compares key
// - protected command ignored, violation flag set
`timescale 1ns/1ps
module fsp_cfg
    import fsp_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic [REG_ADDR_W-1:0] regAddr,
    input  wire logic [7:0]            regWrData,
    input  wire logic                  regWrStb,
    input  wire logic                  regRdStb,
    output logic      [7:0]            regRdData,
    input  wire logic [7:0]            nvOptions,
    input  wire logic [7:0]            nvProtect,
    input  wire logic [8*KEY_BYTES-1:0] nvKey,
    input  wire logic                  memWrStb,
    input  wire logic [FADDR_W-1:0]    memWrAddr,
    input  wire logic [7:0]            memWrData,
    input  wire logic                  memWrSecure,
    input  wire logic                  dbgProtWr,
    input  wire logic [7:0]            dbgProtData,
    input  wire logic                  cmdLaunch,
    input  wire logic [FADDR_W-1:0]    cmdAddr,
    input  wire logic                  cmdMass,
    input  wire logic                  blankPass,
    output logic                       stepStb,
    output logic      [FADDR_W-1:0]    stepAddr,
    output logic      [7:0]            stepData,
    output logic                       cmdGo,
    output logic                       protViolation,
    output logic                       secure,
    output logic                       vectorRedirectDisable
);

    // ****************************************************************
    // state
    // ****************************************************************
    logic [7:0]             optReg_r;
    logic [7:0]             cfgReg_r;
    logic [7:0]             protReg_r;
    logic                   loaded_r;
    logic                   viol_r;
    fsp_key_t               keyState_r;
    fsp_key_t               keyState_nxt;
    logic [3:0]             keyIdx_r;
    logic                   keyOrder_r;
    logic [8*KEY_BYTES-1:0] keyBuf_r;
    logic                   steer;
    logic                   keyAddrHit;
    logic                   keyWr;
    logic                   keyMatch;
    logic                   protHit;
    logic                   cfgWr;

    assign steer      = cfgReg_r[CFG_STEER];
    assign keyAddrHit = memWrAddr[FADDR_W-1:3] == KEY_BASE[FADDR_W-1:3];
    // debug-sourced writes never reach the comparison buffer
    assign keyWr      = memWrStb && steer && keyAddrHit && memWrSecure;
    assign keyMatch   = keyOrder_r && (keyIdx_r == KEY_COUNT) && (keyBuf_r == nvKey);
    assign cfgWr      = regWrStb && (regAddr == REG_CONFIG);
    // region above {select, all ones} is the protected block; mass erase hits it unless protect disable is set
    assign protHit    = !protReg_r[PROT_DIS] && (cmdMass ||
        (cmdAddr[FADDR_W-1:BLOCK_SHIFT] > protReg_r[PROT_SEL_HI:PROT_SEL_LO]));

    // ****************************************************************
    // nonvolatile load
    // ****************************************************************
    // async reset only takes constants; the flash bytes are copied on the first edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            loaded_r <= 1'b0;
        end else begin
            loaded_r <= 1'b1;
        end
    end

    // ****************************************************************
    // options register
    // ****************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            optReg_r <= OPT_RESET;
        end else if (!loaded_r) begin
            optReg_r <= nvOptions & OPT_IMPL_MASK;
        end else if (blankPass ||
                     (keyState_r == KEY_CHECK && optReg_r[OPT_BACKDOOR] && keyMatch)) begin
            optReg_r[SEC_HI:SEC_LO] <= SEC_UNSECURED;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            secure <= 1'b1;
        end else begin
            // blocks unsecured sources from memory contents
            secure <= optReg_r[SEC_HI:SEC_LO] != SEC_UNSECURED;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vectorRedirectDisable <= 1'b0;
        end else begin
            vectorRedirectDisable <= optReg_r[OPT_NORED];
        end
    end

    // ****************************************************************
    // configuration register
    // ****************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfgReg_r <= CFG_RESET;
        end else if (cfgWr) begin
            cfgReg_r <= regWrData & CFG_IMPL_MASK;
        end
    end

    // ****************************************************************
    // protection register
    // ****************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            protReg_r <= PROT_RESET;
        end else if (!loaded_r) begin
            protReg_r <= nvProtect;
        end else if (dbgProtWr) begin
            protReg_r <= dbgProtData;
        end
        // bus writes to the protection offset fall through untouched
    end

    // ****************************************************************
    // backdoor key sequencer
    // ****************************************************************
    always_comb begin
        keyState_nxt = keyState_r;
        unique case (keyState_r)
            KEY_IDLE:    if (steer) keyState_nxt = KEY_COLLECT;
            KEY_COLLECT: if (!steer) keyState_nxt = KEY_CHECK;
            KEY_CHECK:   keyState_nxt = KEY_IDLE;
            default:     keyState_nxt = KEY_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            keyState_r <= KEY_IDLE;
        end else begin
            keyState_r <= keyState_nxt;
        end
    end

    // bytes must arrive in address order; an out-of-order or ninth key write spoils the attempt
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            keyIdx_r   <= 4'h0;
            keyOrder_r <= 1'b0;
        end else if (keyState_r != KEY_COLLECT) begin
            keyIdx_r   <= 4'h0;
            keyOrder_r <= 1'b1;
        end else if (keyWr) begin
            if (keyIdx_r == KEY_COUNT || memWrAddr[2:0] != keyIdx_r[2:0]) begin
                keyOrder_r <= 1'b0;
            end else begin
                keyIdx_r <= keyIdx_r + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            keyBuf_r <= '0;
        end else if (keyWr && keyState_r == KEY_COLLECT && keyIdx_r != KEY_COUNT) begin
            // first byte lands in the top lane of the compare word
            keyBuf_r[8*KEY_BYTES-1 - 8*keyIdx_r[2:0] -: 8] <= memWrData;
        end
    end

    // ****************************************************************
    // flash command path
    // ****************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stepStb  <= 1'b0;
            stepAddr <= '0;
            stepData <= 8'h00;
        end else begin
            stepStb <= memWrStb && !(steer && keyAddrHit);
            if (memWrStb) begin
                stepAddr <= memWrAddr;
                stepData <= memWrData;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmdGo <= 1'b0;
        end else begin
            cmdGo <= cmdLaunch && loaded_r && !protHit;
        end
    end

    // set wins over a software clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            viol_r <= 1'b0;
        end else if (cmdLaunch && protHit) begin
            viol_r <= 1'b1;
        end else if (regWrStb && regAddr == REG_STATUS && regWrData[STAT_VIOL]) begin
            viol_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            protViolation <= 1'b0;
        end else begin
            protViolation <= (cmdLaunch && protHit) || viol_r;
        end
    end

    // ****************************************************************
    // register read port
    // ****************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdData <= 8'h00;
        end else if (regRdStb) begin
            unique case (regAddr)
                REG_OPTIONS: regRdData <= optReg_r & OPT_IMPL_MASK;
                REG_CONFIG:  regRdData <= cfgReg_r & CFG_IMPL_MASK;
                REG_PROTECT: regRdData <= protReg_r;
                REG_STATUS:  regRdData <= {2'h0, viol_r, 5'h00} & STAT_IMPL_MASK;
                default:     regRdData <= 8'h00;
            endcase
        end else begin
            regRdData <= 8'h00;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    opt_hold_a: assert property (loaded_r |=> $stable(optReg_r[7:2]))
        else $error("options register changed between resets");

    backdoor_off_a: assert property (
        (keyState_r == KEY_CHECK && !optReg_r[OPT_BACKDOOR] && !blankPass && loaded_r)
        |=> $stable(optReg_r[SEC_HI:SEC_LO]))
        else $error("key unlocked with backdoor disabled");

    key_unlock_a: assert property (
        (loaded_r && keyState_r == KEY_CHECK && optReg_r[OPT_BACKDOOR] && keyMatch)
        |-> ##2 !secure)
        else $error("matching key did not unsecure");

    dbg_key_a: assert property (
        (memWrStb && !memWrSecure && keyState_r == KEY_COLLECT) |=> $stable(keyIdx_r))
        else $error("unsecured source advanced key capture");

    sec_decode_a: assert property (
        ##1 (secure == ($past(optReg_r[SEC_HI:SEC_LO]) != SEC_UNSECURED)))
        else $error("security code decoded wrongly");

    blank_unlock_a: assert property (
        (blankPass && loaded_r) |=> optReg_r[SEC_HI:SEC_LO] == SEC_UNSECURED)
        else $error("blank pass did not force unsecured code");

    step_pass_a: assert property (
        (memWrStb && !steer) |=> stepStb && stepAddr == $past(memWrAddr))
        else $error("write not passed as command step");

    key_capture_a: assert property (
        (memWrStb && steer && keyAddrHit) |=> !stepStb)
        else $error("key write leaked into command path");

    prot_user_a: assert property (
        (loaded_r && regWrStb && regAddr == REG_PROTECT && !dbgProtWr) |=> $stable(protReg_r))
        else $error("user write changed protection register");

    prot_dbg_a: assert property (
        (loaded_r && dbgProtWr) |=> protReg_r == $past(dbgProtData))
        else $error("debug write to protection lost");

    prot_refuse_a: assert property (
        (cmdLaunch && protHit) |=> !cmdGo && protViolation)
        else $error("protected command not refused");

    viol_set_a: assert property ((cmdLaunch && protHit) |=> viol_r)
        else $error("violation flag not set on refused command");

    reserved_rd_a: assert property (
        (regRdStb && regAddr == REG_CONFIG) |=> (regRdData & ~CFG_IMPL_MASK) == 8'h00)
        else $error("reserved configuration bits read nonzero");

endmodule // fsp_cfg

// ---- shared/fsp_pkg.sv ----
// ****************************************************************
// register map and field layout
// ****************************************************************
package fsp_pkg;
    localparam int          REG_ADDR_W      = 4;
    localparam logic [3:0]  REG_OPTIONS     = 4'h0;
    localparam logic [3:0]  REG_CONFIG      = 4'h1;
    localparam logic [3:0]  REG_PROTECT     = 4'h2;
    localparam logic [3:0]  REG_STATUS      = 4'h3;

    localparam int          OPT_BACKDOOR    = 7;
    localparam int          OPT_NORED       = 6;
    localparam int          SEC_HI          = 1;
    localparam int          SEC_LO          = 0;
    localparam logic [1:0]  SEC_UNSECURED   = 2'h2;
    localparam logic [7:0]  OPT_IMPL_MASK   = 8'hc3;
    localparam logic [7:0]  OPT_RESET       = 8'h00;

    localparam int          CFG_STEER       = 5;
    localparam logic [7:0]  CFG_IMPL_MASK   = 8'h20;
    localparam logic [7:0]  CFG_RESET       = 8'h00;

    localparam int          PROT_DIS        = 0;
    localparam int          PROT_SEL_HI     = 7;
    localparam int          PROT_SEL_LO     = 1;
    localparam logic [7:0]  PROT_RESET      = 8'h00;

    localparam int          STAT_VIOL       = 5;
    localparam logic [7:0]  STAT_IMPL_MASK  = 8'h20;

    // ****************************************************************
    // flash address space
    // ****************************************************************
    localparam int          FADDR_W         = 16;
    localparam logic [15:0] KEY_BASE        = 16'hffb0;
    localparam int          KEY_BYTES       = 8;
    localparam logic [3:0]  KEY_COUNT       = 4'h8;
    localparam int          BLOCK_SHIFT     = 9;

    // ****************************************************************
    // backdoor key sequencer
    // ****************************************************************
    typedef enum logic [1:0] {
        KEY_IDLE    = 2'b00,
        KEY_COLLECT = 2'b01,
        KEY_CHECK   = 2'b11
    } fsp_key_t;
endpackage

// ---- tb/fsp_cfg_bench.sv ----
`timescale 1ns/1ps
// ****************************************************************
// self-checking bench
// ****************************************************************
module fsp_cfg_bench
    import fsp_pkg::*;
;
    localparam logic [63:0] KEY = 64'h0123456789abcdef;
    logic clk = 1'b0, rst = 1'b1, regWrStb = 1'b0, regRdStb = 1'b0;
    logic cmdLaunch = 1'b0, cmdMass = 1'b0, blankPass = 1'b0;
    logic [3:0]  regAddr = 4'h0;
    logic [7:0]  regWrData = 8'h00, nvOptions = 8'h00, nvProtect = 8'h00;
    logic [15:0] cmdAddr = 16'h0000;
    logic [7:0]  regRdData, memWrData, dbgProtData, stepData;
    logic [15:0] memWrAddr, stepAddr;
    logic memWrStb, memWrSecure, dbgProtWr, stepStb, cmdGo, protViolation;
    logic secure, vectorRedirectDisable;
    int errCount = 0, totalChecks = 0, cycles = 0;

    always #20 clk = ~clk;

    fsp_host_model i_host (.clk(clk), .memWrStb(memWrStb), .memWrAddr(memWrAddr),
        .memWrData(memWrData), .memWrSecure(memWrSecure), .dbgProtWr(dbgProtWr),
        .dbgProtData(dbgProtData));

    fsp_cfg i_dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
        .nvOptions(nvOptions), .nvProtect(nvProtect), .nvKey(KEY), .memWrStb(memWrStb),
        .memWrAddr(memWrAddr), .memWrData(memWrData), .memWrSecure(memWrSecure),
        .dbgProtWr(dbgProtWr), .dbgProtData(dbgProtData), .cmdLaunch(cmdLaunch),
        .cmdAddr(cmdAddr), .cmdMass(cmdMass), .blankPass(blankPass), .stepStb(stepStb),
        .stepAddr(stepAddr), .stepData(stepData), .cmdGo(cmdGo),
        .protViolation(protViolation), .secure(secure),
        .vectorRedirectDisable(vectorRedirectDisable));

    task automatic final_report();
        if (errCount == 0 && totalChecks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // hang guard: the whole run needs well under two thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errCount = errCount + 1;
            final_report();
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        totalChecks = totalChecks + 1;
        if (got !== exp) begin
            errCount = errCount + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // new nonvolatile bytes only take effect through a fresh reset
    task automatic do_reset(input logic [7:0] opt, input logic [7:0] prot);
        @(posedge clk);
        rst       <= 1'b1;
        nvOptions <= opt;
        nvProtect <= prot;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrStb  <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clk);
        regWrStb  <= 1'b0;
        regWrData <= ~d;
    endtask

    task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        regRdStb <= 1'b1;
        regAddr  <= a;
        @(posedge clk);
        regRdStb <= 1'b0;
        #1;
        check(what, {8'h00, exp}, {8'h00, regRdData});
    endtask

    task automatic launch(input logic [15:0] a, input logic m, input logic go, input logic v);
        @(posedge clk);
        cmdLaunch <= 1'b1;
        cmdAddr   <= a;
        cmdMass   <= m;
        @(posedge clk);
        cmdLaunch <= 1'b0;
        cmdAddr   <= ~a;
        #1;
        check("cmdGo", {15'h0, go}, {15'h0, cmdGo});
        check("protViolation", {15'h0, v}, {15'h0, protViolation});
    endtask

    // steer on, eight ordered key bytes, steer off, then let the compare settle
    task automatic key_seq(input logic src, input logic [63:0] k);
        reg_wr(REG_CONFIG, 8'h20);
        for (int i = 0; i < KEY_BYTES; i++) begin
            i_host.mem_write(KEY_BASE + 16'(i), k[63-8*i -: 8], src);
            #1;
            check("stepStb", 16'h0000, {15'h0, stepStb});
        end
        reg_wr(REG_CONFIG, 8'h00);
        repeat (6) @(posedge clk);
        #1;
    endtask

    task automatic t_reset_load();
        do_reset(8'hff, 8'h80);
        reg_rd(REG_OPTIONS, 8'hc3, "options");
        check("vectorRedirectDisable", 16'h1, {15'h0, vectorRedirectDisable});
        check("secure", 16'h1, {15'h0, secure});
        reg_rd(REG_PROTECT, 8'h80, "protect");
        reg_wr(REG_OPTIONS, 8'h00);
        reg_rd(REG_OPTIONS, 8'hc3, "options");
        reg_wr(REG_PROTECT, 8'hff);
        reg_rd(REG_PROTECT, 8'h80, "protect");
        reg_wr(REG_CONFIG, 8'hff);
        reg_rd(REG_CONFIG, 8'h20, "config");
        reg_wr(REG_CONFIG, 8'h00);
        reg_rd(4'hf, 8'h00, "unmapped");
    endtask

    task automatic t_protect();
        i_host.mem_write(16'hffb3, 8'h5a, 1'b1);
        #1;
        check("stepStb", 16'h1, {15'h0, stepStb});
        check("stepAddr", 16'hffb3, stepAddr);
        check("stepData", 16'h005a, {8'h00, stepData});
        launch(16'h8200, 1'b0, 1'b0, 1'b1);
        reg_rd(REG_STATUS, 8'h20, "status");
        reg_wr(REG_STATUS, 8'h20);
        reg_rd(REG_STATUS, 8'h00, "status");
        launch(16'h81ff, 1'b0, 1'b1, 1'b0);
        launch(16'h0000, 1'b1, 1'b0, 1'b1);
        reg_wr(REG_STATUS, 8'h20);
        i_host.dbg_prot(8'h01);
        reg_rd(REG_PROTECT, 8'h01, "protect");
        launch(16'hffff, 1'b0, 1'b1, 1'b0);
    endtask

    task automatic t_security();
        do_reset(8'h40, 8'h00);
        check("secure", 16'h1, {15'h0, secure});
        key_seq(1'b1, KEY);
        check("secure", 16'h1, {15'h0, secure});
        do_reset(8'h81, 8'h00);
        key_seq(1'b0, KEY);
        check("secure", 16'h1, {15'h0, secure});
        key_seq(1'b1, KEY ^ 64'h1);
        check("secure", 16'h1, {15'h0, secure});
        key_seq(1'b1, KEY);
        check("secure", 16'h0, {15'h0, secure});
        reg_rd(REG_OPTIONS, 8'h82, "options");
        do_reset(8'h03, 8'h00);
        @(posedge clk);
        blankPass <= 1'b1;
        @(posedge clk);
        blankPass <= 1'b0;
        @(posedge clk);
        #1;
        check("secure", 16'h0, {15'h0, secure});
        do_reset(8'h02, 8'h00);
        check("secure", 16'h0, {15'h0, secure});
        check("vectorRedirectDisable", 16'h0, {15'h0, vectorRedirectDisable});
    endtask

    initial begin
        t_reset_load();
        t_protect();
        t_security();
        final_report();
    end
endmodule // fsp_cfg_bench

// ---- tb/fsp_host_model.sv ----
`timescale 1ns/1ps
// ****************************************************************
// cpu bus and background debug command model
// ****************************************************************
module fsp_host_model (
    input  wire logic        clk,
    output logic             memWrStb,
    output logic [15:0]      memWrAddr,
    output logic [7:0]       memWrData,
    output logic             memWrSecure,
    output logic             dbgProtWr,
    output logic [7:0]       dbgProtData
);
    initial begin
        memWrStb    = 1'b0;
        memWrAddr   = 16'h0000;
        memWrData   = 8'h00;
        memWrSecure = 1'b0;
        dbgProtWr   = 1'b0;
        dbgProtData = 8'h00;
    end

    // a write always starts one edge after the last ended, so key bytes never land back to back
    task automatic mem_write(input logic [15:0] addr, input logic [7:0] data, input logic src);
        @(posedge clk);
        memWrStb    <= 1'b1;
        memWrAddr   <= addr;
        memWrData   <= data;
        memWrSecure <= src;
        @(posedge clk);
        memWrStb    <= 1'b0;
        memWrAddr   <= ~addr;
        memWrData   <= ~data; // released bus must not keep showing old data
        memWrSecure <= ~src;
    endtask

    task automatic dbg_prot(input logic [7:0] data);
        @(posedge clk);
        dbgProtWr   <= 1'b1;
        dbgProtData <= data;
        @(posedge clk);
        dbgProtWr   <= 1'b0;
        dbgProtData <= ~data;
    endtask
endmodule // fsp_host_model
